// ---- design/asps_device.sv ----
// converter end: frame counter, bit selection and power sequencing
`timescale 1ns/1ps
`include "asps_consts.svh"
module asps_device
  import asps_pkg::*;
(
  input  wire logic   sys_clk_i,
  input  wire logic   reset_n_i,
  asps_link_if.device link,
  input  wire logic   [11:0] sample_i,
  output logic        analog_on_o,
  output logic        digital_on_o,
  output logic        conv_start_o,
  output logic        out_on_o
);
  // ==========================================================================
  // pin synchronisers
  logic cs_n_s;
  logic sclk_s;
  logic sclk_d;
  logic cs_n_d;
  asps_sync #(
    .RST_VAL (1'b1)
  ) u_cs (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (link.chip_select_n),
    .sync_o    (cs_n_s)
  );
  asps_sync #(
    .RST_VAL (1'b0)
  ) u_ck (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (link.sclk),
    .sync_o    (sclk_s)
  );
  // ==========================================================================
  // edge detection and frame count
  logic       [4:0] fall_cnt;
  asps_result_t     result;
  logic             dout;
  logic             oe;
  logic             an_on;
  logic             rep_ok;
  wire sclk_fall = sclk_d & ~sclk_s;
  wire cs_fall   = cs_n_d & ~cs_n_s;
  wire active    = ~cs_n_s;
  wire [4:0] nxt_cnt = (fall_cnt == `ASPS_FALL_MAX) ? fall_cnt : fall_cnt + 5'h01;
  // bit index: MSB-first then LSB-first repeat skipping B0
  wire [4:0] msb_idx = `ASPS_FALL_LSB - nxt_cnt;
  wire [4:0] rep_idx = nxt_cnt - `ASPS_FALL_LSB;
  wire       in_msb  = (nxt_cnt >= `ASPS_FALL_MSB) && (nxt_cnt <= `ASPS_FALL_LSB);
  // repeat ends with B11; the fall after it (fall 26) releases the line
  wire       in_rep  = rep_ok && (nxt_cnt > `ASPS_FALL_LSB) && (nxt_cnt < `ASPS_FALL_LAST);
  wire       next_dout = in_msb ? result[msb_idx[3:0]] : in_rep ? result[rep_idx[3:0]] : 1'b0;
  wire       next_oe   = (nxt_cnt >= `ASPS_FALL_NULL) && (in_msb || in_rep || nxt_cnt == `ASPS_FALL_NULL);
  // analog off at fall 14 (fall 16 also decoded, repeat or not), or select rise
  wire       an_stop   = (nxt_cnt == `ASPS_FALL_AN_OFF) || (nxt_cnt == `ASPS_FALL_AN_OFF2);
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sclk_d   <= 1'b0;
      cs_n_d   <= 1'b1;
      fall_cnt <= 5'h00;
      result   <= 12'h000;
      dout     <= 1'b0;
      oe       <= 1'b0;
      an_on    <= 1'b0;
      rep_ok   <= 1'b0;
    end else begin
      sclk_d <= sclk_s;
      cs_n_d <= cs_n_s;
      if (!active) begin
        fall_cnt <= 5'h00; // RULE16
        oe       <= 1'b0; // RULE13
        an_on    <= 1'b0; // RULE1
        rep_ok   <= 1'b0;
      end else if (cs_fall) begin
        // new conversion only on a fresh select fall; two's complement kept as given
        result <= sample_i; // RULE14 RULE15
        an_on  <= 1'b1;
        rep_ok <= 1'b1;
      end else if (sclk_fall) begin
        fall_cnt <= nxt_cnt; // RULE16
        dout     <= next_dout; // RULE12 RULE3
        oe       <= next_oe; // RULE6 RULE7
        if (an_stop) begin
          an_on <= 1'b0; // RULE1
        end
      end
    end
  end
  assign link.serial_result_out = dout;
  assign link.serial_result_oe  = oe;
  assign analog_on_o  = an_on;
  assign digital_on_o = active; // RULE2
  assign conv_start_o = cs_fall;
  assign out_on_o     = oe;
endmodule : asps_device

// ---- design/asps_host.sv ----
// host end: drives select and divided clock, assembles result word
`timescale 1ns/1ps
`include "asps_consts.svh"
module asps_host
  import asps_pkg::*;
(
  input  wire logic  sys_clk_i,
  input  wire logic  reset_n_i,
  asps_link_if.host  link,
  input  wire logic  start_i,
  input  wire logic  [4:0] bits_i,
  output logic       busy_o,
  output logic       done_o,
  output asps_result_t result_o
);
  // ==========================================================================
  // frame engine
  asps_host_e        state;
  logic [`ASPS_DIV_W-1:0] div;
  logic [4:0]        rise_cnt;
  logic [4:0]        goal;
  logic [12:0]       shreg;
  logic              cs_n;
  logic              sclk;
  logic              done;
  logic              din_s;
  asps_sync #(
    .RST_VAL (1'b0)
  ) u_din (
    .sys_clk_i (sys_clk_i),
    .reset_n_i (reset_n_i),
    .async_i   (link.serial_result_out),
    .sync_o    (din_s)
  );
  wire half = (div == `ASPS_DIV_W'(`ASPS_HALF_DIV - 1));
  wire [4:0] next_goal = (bits_i == 5'h00 || bits_i > `ASPS_HOST_BITS) ? `ASPS_HOST_BITS : bits_i;
  // a bit is taken a half period after the fall that launched it, past the device's lag
  // only the twelve bits after the null bit are kept; repeat bits are ignored
  wire        sample_on  = (rise_cnt >= `ASPS_FALL_MSB) && (rise_cnt <= `ASPS_FALL_LSB);
  wire [12:0] next_shreg = sample_on ? {shreg[11:0], din_s} : shreg;
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state    <= ASPS_H_IDLE;
      div      <= '0;
      rise_cnt <= 5'h00;
      goal     <= 5'h00;
      shreg    <= 13'h0000;
      cs_n     <= 1'b1;
      sclk     <= 1'b0;
      done     <= 1'b0;
      result_o <= 12'h000;
    end else begin
      done <= 1'b0;
      div  <= half ? '0 : div + `ASPS_DIV_W'(1);
      case (state)
        ASPS_H_IDLE: begin
          div <= '0;
          if (start_i) begin
            cs_n     <= 1'b0; // RULE8
            rise_cnt <= 5'h00;
            shreg    <= 13'h0000;
            goal     <= next_goal; // RULE4 RULE3
            state    <= ASPS_H_LOW;
          end
        end
        ASPS_H_LOW: begin
          if (half) begin
            sclk  <= 1'b1;
            shreg <= next_shreg; // RULE17
            state <= ASPS_H_HIGH;
          end
        end
        ASPS_H_HIGH: begin
          if (half) begin
            sclk     <= 1'b0;
            rise_cnt <= rise_cnt + 5'h01;
            state    <= (rise_cnt + 5'h01 >= goal) ? ASPS_H_DONE : ASPS_H_LOW;
          end
        end
        ASPS_H_DONE: begin
          // last bit needs a half period to settle before select goes high
          if (half) begin
            cs_n     <= 1'b1; // RULE10
            done     <= 1'b1;
            shreg    <= next_shreg; // RULE17
            // short frames come out left aligned, missing low bits zero
            result_o <= (goal >= `ASPS_FALL_LSB) ? next_shreg[11:0] : next_shreg[11:0] << (`ASPS_FALL_LSB - goal);
            state    <= ASPS_H_IDLE;
          end
        end
        default: state <= ASPS_H_IDLE;
      endcase
    end
  end
  assign link.chip_select_n = cs_n;
  assign link.sclk          = sclk; // RULE5 RULE9 RULE11
  assign busy_o             = (state != ASPS_H_IDLE);
  assign done_o             = done;
endmodule : asps_host

// ---- design/asps_sync.sv ----
// two-flop synchroniser
`timescale 1ns/1ps
module asps_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic sys_clk_i,
  input  wire logic reset_n_i,
  input  wire logic async_i,
  output logic      sync_o
);
  logic meta;
  // both flops reset to the pin's idle level, so no false edge follows reset
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      meta   <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta   <= async_i;
      sync_o <= meta;
    end
  end
endmodule : asps_sync

// ---- dv/adc_serial_power_sequencer_tb_top.sv ----
// testbench joining host and converter ends over the link
`timescale 1ns/1ps
module adc_serial_power_sequencer_tb_top;
  import asps_pkg::*;
  logic         sys_clk_i  = 1'b0;
  logic         reset_n_i  = 1'b0;
  logic         start_i    = 1'b0;
  logic [4:0]   bits_i     = 5'h10;
  logic [11:0]  sample_i   = 12'h000;
  logic         analog_on, digital_on, conv_start, out_on, busy, done, sclk_q;
  logic [4:0]   nf;
  asps_result_t result;
  int           n_fail = 0;
  int           total_checks = 0;
  int           cycles = 0;
  int           n_conv = 0;
  // sample, clocks per frame, expected word; short frames keep the top bits only
  localparam logic [28:0] ROWS [6] = '{{12'h7FF, 5'h10, 12'h7FF}, {12'h800, 5'h0E, 12'h800},
    {12'hFFF, 5'h00, 12'hFFF}, {12'h000, 5'h10, 12'h000}, {12'hA5C, 5'h08, 12'hA40}, {12'h5A3, 5'h14, 12'h5A3}};
  always #2.5 sys_clk_i = ~sys_clk_i;
  asps_link_if asps_link_if_inst ();
  asps_device asps_device_inst (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .link(asps_link_if_inst),
    .sample_i(sample_i), .analog_on_o(analog_on), .digital_on_o(digital_on), .conv_start_o(conv_start),
    .out_on_o(out_on));
  asps_host asps_host_inst (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .link(asps_link_if_inst),
    .start_i(start_i), .bits_i(bits_i), .busy_o(busy), .done_o(done), .result_o(result));
  asps_link_monitor asps_link_monitor_inst (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .chip_select_n(asps_link_if_inst.chip_select_n), .sclk(asps_link_if_inst.sclk),
    .serial_result_out(asps_link_if_inst.serial_result_out), .serial_result_oe(asps_link_if_inst.serial_result_oe));
  // ==========================================================================
  // frame fall counter, conversions, hang guard
  always @(posedge sys_clk_i) begin
    sclk_q <= asps_link_if_inst.sclk;
    nf <= asps_link_if_inst.chip_select_n ? 5'h00 : nf + 5'(sclk_q & ~asps_link_if_inst.sclk);
    n_conv <= n_conv + int'(conv_start === 1'b1);
    cycles <= cycles + 1;
    if (cycles > 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict();
    if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict
  task automatic run_frame(input logic [11:0] s, input logic [4:0] b, input logic [11:0] exp);
    int k;
    @(negedge sys_clk_i);
    sample_i = s;
    bits_i   = b;
    start_i  = 1'b1;
    @(negedge sys_clk_i);
    start_i = 1'b0;
    repeat (100) @(negedge sys_clk_i);
    check({10'h000, digital_on, busy}, 12'h003);
    check(12'(analog_on), 12'h001);
    k = 0;
    // full frames: past fall 14 the analog part is off, digital still on
    while (b == 5'h10 && nf !== 5'h0F && k < 1500) begin @(negedge sys_clk_i); k++; end
    if (b == 5'h10) begin
      check({11'h000, analog_on, digital_on}, 12'h001);
      repeat (10) @(negedge sys_clk_i);
      check({10'h000, asps_link_if_inst.serial_result_oe, asps_link_if_inst.serial_result_out}, {11'h001, s[1]});
    end
    k = 0;
    while (done !== 1'b1 && k < 2000) begin @(negedge sys_clk_i); k++; end
    check(12'(done), 12'h001);
    check(result, exp);
    repeat (6) @(negedge sys_clk_i);
    check({8'h00, busy, analog_on, digital_on, out_on}, 12'h000);
  endtask : run_frame
  // ==========================================================================
  // main sequence
  initial begin
    repeat (8) @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    for (int i = 0; i < 6; i++) run_frame(ROWS[i][28:17], ROWS[i][16:12], ROWS[i][11:0]);
    check(12'(n_conv), 12'h006);
    // reset in mid-frame, then a clean frame
    start_i = 1'b1;
    @(negedge sys_clk_i);
    start_i = 1'b0;
    repeat (300) @(negedge sys_clk_i);
    reset_n_i = 1'b0;
    @(negedge sys_clk_i);
    check({8'h00, asps_link_if_inst.chip_select_n, asps_link_if_inst.serial_result_oe, digital_on, analog_on},
      12'h008);
    repeat (3) @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    run_frame(12'h123, 5'h10, 12'h123);
    check(12'(n_conv), 12'h008);
    print_verdict();
  end
endmodule : adc_serial_power_sequencer_tb_top

// ---- dv/asps_link_monitor.sv ----
// checker for the wire-level behaviour of the converter serial link
`timescale 1ns/1ps
module asps_link_monitor (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic chip_select_n,
  input wire logic sclk,
  input wire logic serial_result_out,
  input wire logic serial_result_oe
);
  // ==========================================================================
  // clock falls in the current frame
  logic       sclk_q;
  logic [4:0] n_fall;
  wire        fall_seen   = sclk_q & ~sclk & ~chip_select_n;
  wire  [4:0] next_n_fall = chip_select_n ? 5'h00 : n_fall + 5'(fall_seen);
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sclk_q <= 1'b0;
      n_fall <= 5'h00;
    end else begin
      sclk_q <= sclk;
      n_fall <= next_n_fall;
    end
  end
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);
  // ==========================================================================
  // assertions
  sequence s_hi8; sclk [*8]; endsequence
  sequence s_lo8; (!sclk) [*8]; endsequence
  // settled low phase, well clear of the device's three-cycle lag
  sequence s_settled; $fell(sclk) ##8 !chip_select_n; endsequence
  property p_clk_high; $rose(sclk) |-> s_hi8; endproperty
  a_clk_high: assert property (p_clk_high) else $error("clock high phase too short");
  property p_clk_low; $fell(sclk) |-> s_lo8; endproperty
  a_clk_low: assert property (p_clk_low) else $error("clock low phase too short");
  property p_cs_fall; $fell(chip_select_n) |-> !sclk; endproperty
  a_cs_fall: assert property (p_cs_fall) else $error("select fell with clock high");
  property p_null; $rose(sclk) && !chip_select_n && n_fall < 5'h02 |-> !serial_result_oe; endproperty
  a_null: assert property (p_null) else $error("output enabled before fall two");
  property p_drive; $rose(sclk) && !chip_select_n && n_fall >= 5'h02 |-> serial_result_oe; endproperty
  a_drive: assert property (p_drive) else $error("output not driven in frame");
  property p_hold; s_settled |=> $stable(serial_result_out) [*8]; endproperty
  a_hold: assert property (p_hold) else $error("data moved inside clock period");
  property p_off; chip_select_n [*5] |-> !serial_result_oe; endproperty
  a_off: assert property (p_off) else $error("line driven with select high");
  property p_oe_fall; $fell(serial_result_oe) |-> chip_select_n; endproperty
  a_oe_fall: assert property (p_oe_fall) else $error("line released with select low");
endmodule : asps_link_monitor

// ---- shared/asps_consts.svh ----
// constants for the converter serial readout and power sequencer
// ==========================================================================
// Operation
// [RULE1] analog powers down at select rise or edge 14/16
// [RULE2] digital part off only while select high
// [RULE3] bits driven when generated; host may stop early
// [RULE4] host may short-cycle frames to 14 clocks; host here accepts any count from 1 to 16 clocks
// [RULE5] host clocks 16x sample rate, or burst
// [RULE6] after last bit, output off, line released
// [RULE7] select low past fall 15 extends output
// [RULE8] host drops select only while clock low
// [RULE9] below 50ksps host clocks at 3.2 MHz
// [RULE10] host stops clock while device powered down
// [RULE11] host keeps clock between 0.8 and 4.8 MHz
// [RULE12] null bit at fall 2, MSB at fall 3
// [RULE13] repeat LSB-first after LSB, then release
// [RULE14] new conversion only after select high then low
// [RULE15] result is twelve-bit two's complement
// [RULE16] count clock falls from select fall
// [RULE17] host samples on rise, drops null bit
`ifndef ASPS_CONSTS_SVH
`define ASPS_CONSTS_SVH
// ==========================================================================
// frame edge numbers (falling clock edges after select fall)
`define ASPS_RES_W         12
`define ASPS_FALL_NULL     5'h02
`define ASPS_FALL_MSB      5'h03
`define ASPS_FALL_LSB      5'h0E
`define ASPS_FALL_AN_OFF   5'h0E
`define ASPS_FALL_REPEAT   5'h0F
`define ASPS_FALL_AN_OFF2  5'h10
`define ASPS_FALL_LAST     5'h1A
`define ASPS_FALL_MAX      5'h1F
`define ASPS_HOST_BITS     5'h10
// host clock: 3.2 MHz from 200 MHz, half period in cycles
`define ASPS_CLK_FREQ_KHZ  200000
`define ASPS_SCLK_FREQ_KHZ 3200
`define ASPS_HALF_DIV      (`ASPS_CLK_FREQ_KHZ / (2 * `ASPS_SCLK_FREQ_KHZ))
`define ASPS_DIV_W         6
`endif

// ---- shared/asps_link_if.sv ----
// serial link between host controller and converter
`timescale 1ns/1ps
interface asps_link_if;
  logic chip_select_n;
  logic sclk;
  logic serial_result_out;
  logic serial_result_oe;
  modport device (
    input  chip_select_n,
    input  sclk,
    output serial_result_out,
    output serial_result_oe
  );
  modport host (
    output chip_select_n,
    output sclk,
    input  serial_result_out,
    input  serial_result_oe
  );
endinterface : asps_link_if

// ---- shared/asps_pkg.sv ----
// types shared by both ends of the converter link
package asps_pkg;
  typedef logic [11:0] asps_result_t;
  typedef enum logic [1:0] {
    ASPS_H_IDLE  = 2'b00,
    ASPS_H_LOW   = 2'b01,
    ASPS_H_HIGH  = 2'b11,
    ASPS_H_DONE  = 2'b10
  } asps_host_e;
endpackage : asps_pkg
